// [rtl/hcsp_pkg.sv]
// constants and types for the host command serial port
package hcsp_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_NS = 5;
  localparam int CMD_BYTES = 8;
  localparam logic [7:0] ADDR_QRY_LO = 8'h20;
  localparam logic [7:0] ADDR_QRY_HI = 8'h23;
  localparam logic [7:0] ADDR_TRIM = 8'h23;
  localparam logic [7:0] ADDR_FETCH = 8'h25;
  localparam logic [7:0] ACK_BYTE = 8'h01;
  localparam logic [2:0] LAST_BYTE = 3'(CMD_BYTES - 1);
  localparam int BUSY_MIN_NS = 40_000;
  localparam int BUSY_MAX_NS = 300_000;
  localparam int BUSY_MIN_CYC = (BUSY_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_MAX_CYC = BUSY_MAX_NS / CLK_NS;
  localparam int BAUD_PIN_LOW = 57600;
  localparam int BAUD_FACTORY = 115200;
  localparam logic [15:0] DIV_PIN_LOW = 16'(CLK_HZ / BAUD_PIN_LOW);
  localparam logic [15:0] DIV_FACTORY = 16'(CLK_HZ / BAUD_FACTORY);
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [3:0] UART_STOP_BIT = 4'h9;
  localparam logic [9:0] UART_IDLE = 10'h3ff;
  typedef enum logic [1:0] {HCSP_COLLECT, HCSP_BUSY, HCSP_REPLY} hcsp_state_t;
endpackage

// [rtl/hcsp_top.sv]
// host command port: spi slave and uart front end of the command interpreter
//
// Summary of operation
// - commands are eight bytes, address first, msb first
// - spi data shifts on sclk falling edge
// - ready drops while a command is processed
// - spi bytes are dropped while ready is low
// - after address byte, wait for seven more
// - processing ends between 40 and 300 us
// - miso returns output buffer msb first
// - returned data only meaningful on fetch
// - fetch returns result of last query 0x20-0x23
// - fetch register works on spi only
// - trim query returns 16-bit value, upper zero
// - uart is 8N1 without flow control
// - strap low gives 57600, high stored rate
// - new baud rate applies only after reset
// - uart query answers with eight bytes
// - uart config command answers ack 0x01
// - spi fetch empties the output buffer
`timescale 1ns/1ps
module hcsp_top #(
  parameter int BUSY_MIN = hcsp_pkg::BUSY_MIN_CYC,
  parameter int BUSY_MAX = hcsp_pkg::BUSY_MAX_CYC
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset
  input wire logic spiSclk, // spi clock from host
  input wire logic spiCsN, // spi chip select
  input wire logic spiMosi, // host to device data
  output logic spiMiso, // device to host data
  output logic spiMisoOe, // miso drive enable
  output logic commandReadyOut, // high when a command may be sent
  input wire logic uartRx, // uart receive pin
  output logic uartTx, // uart transmit pin
  input wire logic uartBaudSel, // baud strap pin
  input wire logic [15:0] storedBaudDiv, // programmed baud divisor, 0 = factory
  output logic cmdValid, // command pulse to processor
  output logic [7:0] cmdAddr, // command register address
  output logic [55:0] cmdData, // command data bytes
  input wire logic cmdDone, // processor finished command
  input wire logic [63:0] resultData, // query result from processor
  input wire logic [15:0] trimValue, // oscillator trim converter value
  output logic outBufFull // output buffer holds a result
);
  import hcsp_pkg::*;

  localparam logic [16:0] MIN_C = 17'(BUSY_MIN);
  localparam logic [16:0] MAX_C = 17'(BUSY_MAX);

  function automatic logic [7:0] pickByte(input logic [63:0] w, input logic [2:0] i);
    pickByte = w[(7 - int'(i)) * 8 +: 8];
  endfunction

  // ---------------- link clock domain
  logic [2:0] bitCnt_r;
  logic [6:0] spiSh_r;
  logic [7:0] spiByte_r;
  logic [7:0] misoSh_r;
  logic spiTgl_r;
  logic [7:0] txByte_r;

  // chip select high restarts byte framing
  always_ff @(negedge spiSclk or posedge spiCsN) begin
    if (spiCsN) begin
      bitCnt_r <= 3'h0;
    end else begin
      bitCnt_r <= bitCnt_r + 3'h1;
    end
  end

  // both directions move on the falling edge
  always_ff @(negedge spiSclk or negedge rst_n) begin
    if (!rst_n) begin
      spiSh_r <= 7'h00;
      spiByte_r <= 8'h00;
      misoSh_r <= 8'h00;
      spiTgl_r <= 1'b0;
    end else begin
      spiSh_r <= {spiSh_r[5:0], spiMosi};
      misoSh_r <= (bitCnt_r == 3'h0) ? {txByte_r[6:0], 1'b0} : {misoSh_r[6:0], 1'b0};
      if (bitCnt_r == 3'h7) begin
        spiByte_r <= {spiSh_r, spiMosi};
        spiTgl_r <= ~spiTgl_r;
      end
    end
  end

  // txByte_r is quasi-static: it only moves after a byte ends, well inside the host gap
  assign spiMiso = (bitCnt_r == 3'h0) ? txByte_r[7] : misoSh_r[7];
  assign spiMisoOe = ~spiCsN;

  // ---------------- system domain
  logic [2:0] tglSync_r;
  logic [1:0] rxSync_r;
  logic [1:0] selSync_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tglSync_r <= 3'h0;
      rxSync_r <= 2'h3;
      selSync_r <= 2'h0;
    end else begin
      tglSync_r <= {tglSync_r[1:0], spiTgl_r};
      rxSync_r <= {rxSync_r[0], uartRx};
      selSync_r <= {selSync_r[0], uartBaudSel};
    end
  end
  wire spiEv = tglSync_r[2] ^ tglSync_r[1];
  wire rxPin = rxSync_r[1];

  // divisor caught once after reset release, so a reprogrammed rate waits for reset
  logic [1:0] latchCnt_r;
  logic [15:0] baudDiv_r;
  wire latchDone = (latchCnt_r == STRAP_WAIT);
  wire [15:0] highDiv = (storedBaudDiv != 16'h0000) ? storedBaudDiv : DIV_FACTORY;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latchCnt_r <= 2'h0;
      baudDiv_r <= DIV_PIN_LOW;
    end else if (!latchDone) begin
      latchCnt_r <= latchCnt_r + 2'h1;
      if (latchCnt_r == STRAP_WAIT - 2'h1) begin
        baudDiv_r <= selSync_r[1] ? highDiv : DIV_PIN_LOW;
      end
    end
  end

  // uart receiver, 8N1 lsb first
  logic rxBusy_r;
  logic [15:0] rxDiv_r;
  logic [3:0] rxBit_r;
  logic [7:0] uRxSh_r;
  logic uRxEv_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxBusy_r <= 1'b0;
      rxDiv_r <= 16'h0000;
      rxBit_r <= 4'h0;
      uRxSh_r <= 8'h00;
      uRxEv_r <= 1'b0;
    end else begin
      uRxEv_r <= 1'b0;
      if (!rxBusy_r) begin
        if (latchDone && !rxPin) begin
          rxBusy_r <= 1'b1;
          rxDiv_r <= {1'b0, baudDiv_r[15:1]};
          rxBit_r <= 4'h0;
        end
      end else if (rxDiv_r != 16'h0000) begin
        rxDiv_r <= rxDiv_r - 16'h0001;
      end else begin
        rxDiv_r <= baudDiv_r - 16'h0001;
        rxBit_r <= rxBit_r + 4'h1;
        if (rxBit_r == 4'h0) begin
          rxBusy_r <= ~rxPin; // glitch, not a start bit
        end else if (rxBit_r != UART_STOP_BIT) begin
          uRxSh_r <= {rxPin, uRxSh_r[7:1]};
        end else begin
          rxBusy_r <= 1'b0;
          uRxEv_r <= rxPin;
        end
      end
    end
  end

  // command collector and sequencer
  hcsp_state_t state_r;
  logic [2:0] byteCnt_r;
  logic [63:0] cmd_r;
  logic srcUart_r;
  logic [16:0] busyCnt_r;
  logic doneSeen_r;
  logic [63:0] outBuf_r;
  logic outFull_r;
  logic [2:0] txLeft_r;
  logic cmdValid_r;
  logic [7:0] cmdAddr_r;
  logic [55:0] cmdData_r;
  logic txBusy_r;

  wire [7:0] byteIn = spiEv ? spiByte_r : uRxSh_r;
  wire collecting = (state_r == HCSP_COLLECT);
  // while not collecting, incoming bytes fall on the floor
  wire accept = collecting && (spiEv || uRxEv_r);
  wire lastByte = accept && (byteCnt_r == LAST_BYTE);
  wire [7:0] addrNow = cmd_r[55:48];
  wire [7:0] addr = cmd_r[63:56];
  wire isQuery = (addr >= ADDR_QRY_LO) && (addr <= ADDR_QRY_HI);
  wire isFetch = (addr == ADDR_FETCH);
  wire [63:0] qData = (addr == ADDR_TRIM) ? {48'h0, trimValue} : resultData;
  wire finish = (state_r == HCSP_BUSY) &&
                (((doneSeen_r || cmdDone) && busyCnt_r >= MIN_C) || busyCnt_r >= MAX_C);
  wire replyNow = finish && srcUart_r && !isFetch;
  wire txNext = (state_r == HCSP_REPLY) && !txBusy_r && (txLeft_r != 3'h0);
  wire txLoad = replyNow || txNext;
  wire [7:0] txData = replyNow ? (isQuery ? qData[63:56] : ACK_BYTE) :
                      pickByte(outBuf_r, 3'(4'h8 - {1'b0, txLeft_r}));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= HCSP_COLLECT;
      byteCnt_r <= 3'h0;
      cmd_r <= 64'h0;
      srcUart_r <= 1'b0;
      busyCnt_r <= 17'h0;
      doneSeen_r <= 1'b0;
      cmdValid_r <= 1'b0;
      cmdAddr_r <= 8'h00;
      cmdData_r <= 56'h0;
      txLeft_r <= 3'h0;
    end else begin
      cmdValid_r <= 1'b0;
      unique case (state_r)
        HCSP_COLLECT: begin
          if (accept) begin
            cmd_r <= {cmd_r[55:0], byteIn};
            byteCnt_r <= byteCnt_r + 3'h1;
            srcUart_r <= ~spiEv;
          end
          if (lastByte) begin
            state_r <= HCSP_BUSY;
            busyCnt_r <= 17'h0;
            doneSeen_r <= (addrNow == ADDR_FETCH);
            cmdValid_r <= (addrNow != ADDR_FETCH);
            cmdAddr_r <= addrNow;
            cmdData_r <= {cmd_r[47:0], byteIn};
          end
        end
        HCSP_BUSY: begin
          busyCnt_r <= busyCnt_r + 17'h1;
          if (cmdDone) begin
            doneSeen_r <= 1'b1;
          end
          if (finish) begin
            state_r <= replyNow ? HCSP_REPLY : HCSP_COLLECT;
            txLeft_r <= (replyNow && isQuery) ? 3'h7 : 3'h0;
          end
        end
        HCSP_REPLY: begin
          if (txNext) begin
            txLeft_r <= txLeft_r - 3'h1;
          end else if (!txBusy_r && !txLoad) begin
            state_r <= HCSP_COLLECT;
          end
        end
      endcase
    end
  end

  // output buffer: loaded by queries, emptied by a spi fetch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      outBuf_r <= 64'h0;
      outFull_r <= 1'b0;
      txByte_r <= 8'h00;
    end else begin
      txByte_r <= pickByte(outBuf_r, byteCnt_r);
      if (finish && isQuery) begin
        outBuf_r <= qData;
        outFull_r <= 1'b1;
      end else if (finish && isFetch && !srcUart_r) begin
        outBuf_r <= 64'h0;
        outFull_r <= 1'b0;
      end
    end
  end

  // uart transmitter, start bit low then lsb first
  logic [9:0] txSh_r;
  logic [15:0] txDiv_r;
  logic [3:0] txBit_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txSh_r <= UART_IDLE;
      txDiv_r <= 16'h0000;
      txBit_r <= 4'h0;
      txBusy_r <= 1'b0;
    end else if (txLoad) begin
      txSh_r <= {1'b1, txData, 1'b0};
      txDiv_r <= baudDiv_r - 16'h0001;
      txBit_r <= 4'h0;
      txBusy_r <= 1'b1;
    end else if (txBusy_r) begin
      if (txDiv_r != 16'h0000) begin
        txDiv_r <= txDiv_r - 16'h0001;
      end else begin
        txSh_r <= {1'b1, txSh_r[9:1]};
        txDiv_r <= baudDiv_r - 16'h0001;
        txBit_r <= txBit_r + 4'h1;
        txBusy_r <= (txBit_r != UART_STOP_BIT);
      end
    end
  end

  assign uartTx = txSh_r[0];
  assign commandReadyOut = collecting;
  assign cmdValid = cmdValid_r;
  assign cmdAddr = cmdAddr_r;
  assign cmdData = cmdData_r;
  assign outBufFull = outFull_r;

  // ---------------- checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_ready_drop;
    lastByte |=> !commandReadyOut ##0 (state_r == HCSP_BUSY);
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready stayed high after command");

  property p_discard;
    !collecting && spiEv |=> $stable(cmd_r) && $stable(byteCnt_r);
  endproperty
  a_discard: assert property (p_discard) else $error("byte taken while busy");

  property p_min_busy;
    (state_r == HCSP_BUSY) && $past(state_r == HCSP_BUSY) && (state_r != $past(state_r, 2)) |-> !finish;
  endproperty
  a_min_busy: assert property (p_min_busy) else $error("command finished too early");

  property p_max_busy;
    (state_r == HCSP_BUSY) |-> busyCnt_r <= MAX_C && (busyCnt_r >= MIN_C || !finish);
  endproperty
  a_max_busy: assert property (p_max_busy) else $error("busy window out of range");

  property p_cmd_out;
    lastByte && addrNow != ADDR_FETCH |=> cmdValid && cmdAddr == $past(addrNow) ##1 !cmdValid;
  endproperty
  a_cmd_out: assert property (p_cmd_out) else $error("command not issued once");

  property p_fetch_clear;
    finish && isFetch && !srcUart_r |=> !outBufFull && outBuf_r == 64'h0;
  endproperty
  a_fetch_clear: assert property (p_fetch_clear) else $error("fetch left buffer full");

  property p_trim;
    finish && addr == ADDR_TRIM |=> outBuf_r == {48'h0, $past(trimValue)} && outBufFull;
  endproperty
  a_trim: assert property (p_trim) else $error("trim result malformed");

  property p_ack;
    replyNow && !isQuery |=> txSh_r == {1'b1, ACK_BYTE, 1'b0} && !uartTx && txLeft_r == 3'h0;
  endproperty
  a_ack: assert property (p_ack) else $error("ack byte not sent");

  property p_query_len;
    replyNow && isQuery |=> txLeft_r == 3'h7 ##0 state_r == HCSP_REPLY;
  endproperty
  a_query_len: assert property (p_query_len) else $error("query reply not eight bytes");

  property p_no_uart_fetch;
    finish && isFetch && srcUart_r |=> commandReadyOut && !txBusy_r;
  endproperty
  a_no_uart_fetch: assert property (p_no_uart_fetch) else $error("uart fetch answered");

  property p_baud_hold;
    latchDone && $past(latchDone) |-> $stable(baudDiv_r);
  endproperty
  a_baud_hold: assert property (p_baud_hold) else $error("baud changed without reset");

  c_spi_cmd: cover property (lastByte && !srcUart_r && !spiEv == 1'b0);
  c_uart_query: cover property (replyNow && isQuery);
  c_spi_fetch: cover property (finish && isFetch && !srcUart_r && outFull_r);
endmodule

// [sim/hcsp_host_model.sv]
// host model: spi master and uart host driving the command port
`timescale 1ns/1ps
module hcsp_host_model #(
  parameter int BIT_NS = 80
) (
  output logic spiSclk, // spi clock, idle high
  output logic spiCsN, // chip select
  output logic spiMosi, // host data
  input wire logic spiMiso, // device data
  input wire logic spiMisoOe, // miso drive enable
  output logic uartRx, // line to device rx
  input wire logic uartTx // line from device tx
);
  logic [63:0] spiRx;
  initial begin
    spiSclk = 1'b1;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
    uartRx = 1'b1;
  end
  // whole command under one chip select; clock stands still between frames
  task automatic spi_cmd(input logic [63:0] c);
    spiCsN = 1'b0;
    #1000;
    for (int i = 63; i >= 0; i--) begin
      spiMosi = c[i];
      spiRx[i] = spiMisoOe ? spiMiso : 1'bx;
      // bench link clock period is fixed at 12 ns, far above the field rate limit
      #6 spiSclk = 1'b0;
      #6 spiSclk = 1'b1;
      if (i % 8 == 0 && i > 0) #2000;
    end
    #20 spiCsN = 1'b1;
    spiMosi = ~spiMosi;
  endtask
  task automatic uart_send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      uartRx = f[i];
      #(BIT_NS);
    end
  endtask
  task automatic uart_cmd(input logic [63:0] c);
    for (int i = 7; i >= 0; i--) uart_send(c[i*8 +: 8]);
  endtask
  // every reply byte is read out, also the acknowledge
  task automatic uart_recv(output logic [7:0] b);
    @(negedge uartTx);
    #(BIT_NS * 3 / 2);
    for (int i = 0; i < 8; i++) begin
      b[i] = uartTx;
      #(BIT_NS);
    end
  endtask
endmodule

// [sim/tb_top.sv]
// testbench for the host command port
`timescale 1ns/1ps
module tb_top;
  import hcsp_pkg::*;
  localparam int BMIN = 20;
  localparam int BMAX = 200;
  logic clk_sys, rst_n, spiSclk, spiCsN, spiMosi, spiMiso, spiMisoOe;
  logic commandReadyOut, uartRx, uartTx, cmdValid, outBufFull;
  logic uartBaudSel = 1'b1;
  logic [15:0] storedBaudDiv = 16'h0010;
  logic cmdDone = 1'b0;
  logic [63:0] resultData = 64'h0;
  logic [15:0] trimValue = 16'hc3a5;
  logic [7:0] cmdAddr, b;
  logic [55:0] cmdData;
  logic [63:0] exp;
  logic [15:0] busyCyc = 16'h0;
  logic [15:0] lastBusy = 16'h0;
  int nFin = 0;
  int nValid = 0;
  int cyc = 0;
  int failCount = 0;
  int checked = 0;
  int k;
  hcsp_top #(.BUSY_MIN(BMIN), .BUSY_MAX(BMAX)) hcsp_top_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .spiSclk(spiSclk), .spiCsN(spiCsN),
    .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
    .commandReadyOut(commandReadyOut), .uartRx(uartRx), .uartTx(uartTx),
    .uartBaudSel(uartBaudSel), .storedBaudDiv(storedBaudDiv), .cmdValid(cmdValid),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdDone(cmdDone), .resultData(resultData),
    .trimValue(trimValue), .outBufFull(outBufFull));
  hcsp_host_model #(.BIT_NS(80)) hcsp_host_model_inst (
    .spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe), .uartRx(uartRx), .uartTx(uartTx));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // processor stand-in answers at once; busy length is measured here
  always @(posedge clk_sys) begin
    cmdDone <= cmdValid;
    cyc <= cyc + 1;
    if (cmdValid === 1'b1) nValid <= nValid + 1;
    busyCyc <= (!rst_n || commandReadyOut) ? 16'h0 : busyCyc + 16'h1;
    if (commandReadyOut === 1'b1 && busyCyc != 16'h0) begin
      lastBusy <= busyCyc;
      nFin <= nFin + 1;
    end
    if (cyc == 90000) begin
      failCount++;
      end_of_test();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] want);
    checked++;
    if (seen !== want) begin
      failCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wait_fin(input int n);
    while (nFin == n) @(posedge clk_sys);
  endtask
  // returned miso data is only looked at after a fetch
  task automatic spi(input logic [63:0] c);
    int n0;
    n0 = nFin;
    hcsp_host_model_inst.spi_cmd(c);
    wait_fin(n0);
    chk(lastBusy >= BMIN && lastBusy <= BMAX + 2, 1'b1);
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk(commandReadyOut, 1'b1);
    chk(outBufFull, 1'b0);
    chk(uartTx, 1'b1);
    $display("test reset done");
    for (int q = 0; q < 4; q++) begin
      resultData <= {32'h89abcdef, 24'h0, 8'(q)};
      exp = (q == 3) ? {48'h0, trimValue} : {32'h89abcdef, 24'h0, 8'(q)};
      spi({ADDR_QRY_LO + 8'(q), 56'h01});
      chk(cmdAddr, ADDR_QRY_LO + 8'(q));
      chk(cmdData, 56'h01);
      chk(outBufFull, 1'b1);
      // a config between query and fetch must leave the result alone
      if (q == 3) spi({8'h10, 56'h05});
      k = nValid;
      spi({ADDR_FETCH, 56'h0});
      chk(hcsp_host_model_inst.spiRx, exp);
      chk(outBufFull, 1'b0);
      chk(nValid, k);
    end
    spi({ADDR_FETCH, 56'h0});
    chk(hcsp_host_model_inst.spiRx, 64'h0);
    $display("test spi query and fetch done");
    k = nFin;
    hcsp_host_model_inst.uart_cmd({8'h10, 56'h05});
    hcsp_host_model_inst.uart_recv(b);
    chk(b, ACK_BYTE);
    wait_fin(k);
    chk(cmdAddr, 8'h10);
    $display("test uart config done");
    resultData <= 64'hfedcba9876543210;
    k = nFin;
    hcsp_host_model_inst.uart_cmd({8'h21, 56'h0});
    for (int i = 7; i >= 0; i--) begin
      hcsp_host_model_inst.uart_recv(b);
      chk(b, resultData[i*8 +: 8]);
    end
    wait_fin(k);
    chk(cmdAddr, 8'h21);
    $display("test uart query done");
    end_of_test();
  end
endmodule
